// *** core/sar_link_consts.svh ***
// timing counts, bit positions and limits shared by both ends of the serial converter link
`ifndef SAR_LINK_CONSTS_SVH
`define SAR_LINK_CONSTS_SVH

// ----------------------------------------------------------------------------
// word layout
// ----------------------------------------------------------------------------
`define WORD_BITS 16
`define LEAD_ZEROS 4
`define RES_BITS_DEF 12
`define CNT_W 5

// ----------------------------------------------------------------------------
// serial clock falling-edge marks within a frame
// ----------------------------------------------------------------------------
`define TRACK_FALL 5'h0d
`define PD_FALL_LO 5'h02
`define PD_FALL_HI 5'h0a
`define LAST_FALL 5'h10
`define PD_ABORT_FALL 5'h04

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_NS 100
`define ACQUISITION_INTERVAL_NS 290
`define T_QUIET_NS 60
`define ACQ_CYC ((`ACQUISITION_INTERVAL_NS + `CLK_NS - 1) / `CLK_NS)
`define QUIET_CYC ((`T_QUIET_NS + `CLK_NS - 1) / `CLK_NS)
`define SCLK_HALF_DEF 8
`define SCLK_HALF_MIN 5
`define FIRST_LEAD 8'h04

`endif

// *** core/sar_link_pkg.sv ***
// types shared by both ends of the serial converter link
package sar_link_pkg;

  typedef enum logic [1:0] {
    DS_IDLE  = 2'b00,
    DS_SHIFT = 2'b01,
    DS_DONE  = 2'b10
  } dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_HIGH = 2'b01,
    HS_LOW  = 2'b10
  } host_state_t;

endpackage

// *** core/sar_link_if.sv ***
// serial link between the converter end and its host end
`timescale 1ns/1ps
interface sar_link_if;
  logic sclk;
  logic frame_sel_n;
  logic serial_result_out_o;
  logic serial_result_oe;
  wire serial_result_out;

  // no pull on the data line: released, it shows the inverse of the last bit, so a late sample cannot pass
  assign serial_result_out = serial_result_oe ? serial_result_out_o : ~serial_result_out_o;

  modport dev (
    input sclk,
    input frame_sel_n,
    output serial_result_out_o,
    output serial_result_oe
  );

  modport host (
    output sclk,
    output frame_sel_n,
    input serial_result_out
  );
endinterface

// *** core/sar_adc_serial_readout.sv ***
// converter end: frame decode, track/hold control, power-down and serial result shifter
//
// Overview of operation
// - serial clock converts and shifts; frame brackets transfer
// - frame fall: hold, sample, convert, drive data
// - host gives sixteen serial clocks per frame
// - back to track on rise after fall 13
// - release data line on sixteenth falling edge
// - early frame rise aborts and releases line
// - result bits change on serial clock falls
// - twelve-bit: four zeros, twelve bits, MSB first
// - ten-bit: four zeros, ten bits, two zeros
// - result coded in two's complement
// - frame fall gives first zero, fall one second
// - last bit launched fall 15, captured fall 16
// - slow clocks: host may capture on rising edges
// - host leaves 290 ns acquisition before frame
// - host leaves 60 ns quiet after release
// - host bursts 16 clocks at 1 MSPS; here SCLK_HALF of at least 5 cycles of 100 ns gives 16 us or more per frame
// - rise between falls 2 and 10: power-down
// - rise before fall 2 keeps normal mode
// - frame past fall 10 wakes; earlier rise sleeps
// - wake frame: track at first serial clock edge
`timescale 1ns/1ps
`include "sar_link_consts.svh"
module sar_adc_serial_readout
  import sar_link_pkg::*;
#(
  parameter int RES_BITS = `RES_BITS_DEF
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // conversion source, two's complement, RES_BITS wide, all bits used at either resolution
  input wire logic [RES_BITS-1:0] sample_i,
  // status
  output logic track_o,
  output logic power_down_o,
  output logic converting_o,
  output logic sample_take_o,
  output logic done_o,
  // link
  sar_link_if.dev link
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (RES_BITS != 12 && RES_BITS != 10) begin : g_bad_res
    $error("RES_BITS must be 10 or 12");
  end

  localparam int TRAIL_ZEROS = `WORD_BITS - `LEAD_ZEROS - RES_BITS;

  // --------------------------------------------------------------------------
  // word assembly
  // --------------------------------------------------------------------------
  // the source already supplies two's complement, so bits pass unchanged
  function automatic logic [`WORD_BITS-1:0] build_word(input logic [RES_BITS-1:0] code);
    logic [`WORD_BITS-1:0] w;
    w = '0;
    w[`WORD_BITS-`LEAD_ZEROS-1 -: RES_BITS] = code;
    return w;
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] sclk_sync_ff;
  logic [2:0] frame_sync_ff;
  logic sclk_lvl_ff;
  logic frame_n_lvl_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_sync_ff <= 3'h7;
      frame_sync_ff <= 3'h7;
    end else if (ce_i) begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], link.sclk};
      frame_sync_ff <= {frame_sync_ff[1:0], link.frame_sel_n};
    end
  end

  // a level only counts once the second and third stages agree
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_lvl_ff <= 1'b1;
      frame_n_lvl_ff <= 1'b1;
    end else if (ce_i) begin
      if (sclk_sync_ff[1] == sclk_sync_ff[2]) begin
        sclk_lvl_ff <= sclk_sync_ff[2];
      end
      if (frame_sync_ff[1] == frame_sync_ff[2]) begin
        frame_n_lvl_ff <= frame_sync_ff[2];
      end
    end
  end

  logic sclk_agree;
  logic frame_agree;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_fall;
  logic frame_rise;

  assign sclk_agree = sclk_sync_ff[1] == sclk_sync_ff[2];
  assign frame_agree = frame_sync_ff[1] == frame_sync_ff[2];
  assign sclk_fall = sclk_agree && sclk_lvl_ff && !sclk_sync_ff[2];
  assign sclk_rise = sclk_agree && !sclk_lvl_ff && sclk_sync_ff[2];
  assign frame_fall = frame_agree && frame_n_lvl_ff && !frame_sync_ff[2];
  assign frame_rise = frame_agree && !frame_n_lvl_ff && frame_sync_ff[2];

  // --------------------------------------------------------------------------
  // frame sequencer
  // --------------------------------------------------------------------------
  dev_state_t state_ff;
  logic [`CNT_W-1:0] fall_cnt_ff;
  logic [`CNT_W-1:0] nxt_fall_cnt;
  logic in_frame;

  assign nxt_fall_cnt = fall_cnt_ff + `CNT_W'(1);
  assign in_frame = state_ff != DS_IDLE;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= DS_IDLE;
      fall_cnt_ff <= '0;
    end else if (ce_i) begin
      case (state_ff)
        DS_IDLE: begin
          // serial clock edges outside a frame are ignored
          if (frame_fall) begin
            state_ff <= DS_SHIFT;
            fall_cnt_ff <= '0;
          end
        end
        DS_SHIFT: begin
          if (frame_rise) begin
            state_ff <= DS_IDLE;
          end else if (sclk_fall) begin
            fall_cnt_ff <= nxt_fall_cnt;
            if (nxt_fall_cnt == `LAST_FALL) begin
              state_ff <= DS_DONE;
            end
          end
        end
        DS_DONE: begin
          if (frame_rise) begin
            state_ff <= DS_IDLE;
          end
        end
        default: begin
          state_ff <= DS_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // result shifter and data line
  // --------------------------------------------------------------------------
  logic [`WORD_BITS-1:0] shift_ff;
  logic data_ff;
  logic data_oe_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_ff <= '0;
      data_ff <= 1'b0;
      data_oe_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == DS_IDLE) begin
        if (frame_fall) begin
          // the input is captured at the frame fall, the first zero goes out at once
          shift_ff <= build_word(sample_i);
          data_ff <= 1'b0;
          data_oe_ff <= 1'b1;
        end else begin
          data_oe_ff <= 1'b0;
        end
      end else if (frame_rise) begin
        data_oe_ff <= 1'b0;
      end else if (state_ff == DS_SHIFT && sclk_fall) begin
        if (nxt_fall_cnt == `LAST_FALL) begin
          data_oe_ff <= 1'b0;
        end else begin
          // bit 15 went out at the frame fall; fall n presents bit 15-n
          shift_ff <= {shift_ff[`WORD_BITS-2:0], 1'b0};
          data_ff <= shift_ff[`WORD_BITS-2];
        end
      end
    end
  end

  assign link.serial_result_out_o = data_ff;
  assign link.serial_result_oe = data_oe_ff;

  // --------------------------------------------------------------------------
  // power mode
  // --------------------------------------------------------------------------
  logic pd_ff;
  logic waking_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == DS_SHIFT && frame_rise) begin
        // a rise before fall 2 is treated as a glitch and leaves the mode alone
        if (fall_cnt_ff >= `PD_FALL_LO && fall_cnt_ff < `PD_FALL_HI) begin
          pd_ff <= 1'b1;
        end
      end else if (state_ff == DS_SHIFT && sclk_fall && nxt_fall_cnt == `PD_FALL_HI) begin
        pd_ff <= 1'b0;
      end
    end
  end

  // remembers that the current frame started from power-down
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      waking_ff <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == DS_IDLE && frame_fall) begin
        waking_ff <= pd_ff;
      end else if (state_ff == DS_IDLE || sclk_fall || sclk_rise) begin
        waking_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // track and hold
  // --------------------------------------------------------------------------
  logic track_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      track_ff <= 1'b1;
    end else if (ce_i) begin
      if (state_ff == DS_IDLE) begin
        if (frame_fall) begin
          track_ff <= 1'b0;
        end else begin
          // powered down the stage sits in hold
          track_ff <= !pd_ff;
        end
      end else if (frame_rise) begin
        track_ff <= !(state_ff == DS_SHIFT && fall_cnt_ff >= `PD_FALL_LO && fall_cnt_ff < `PD_FALL_HI);
      end else if (waking_ff && (sclk_fall || sclk_rise)) begin
        track_ff <= 1'b1;
      end else if (sclk_rise && fall_cnt_ff >= `TRACK_FALL) begin
        track_ff <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // status pulses
  // --------------------------------------------------------------------------
  logic take_ff;
  logic done_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce_i) begin
      take_ff <= state_ff == DS_IDLE && frame_fall;
      done_ff <= state_ff == DS_SHIFT && !frame_rise && sclk_fall && nxt_fall_cnt == `LAST_FALL;
    end
  end

  assign track_o = track_ff;
  assign power_down_o = pd_ff;
  assign converting_o = in_frame;
  assign sample_take_o = take_ff;
  assign done_o = done_ff;

endmodule

// *** core/sar_host_reader.sv ***
// host end: frame and serial clock generation, result capture and two-entry word buffer
`timescale 1ns/1ps
`include "sar_link_consts.svh"
module sar_host_reader
  import sar_link_pkg::*;
#(
  parameter int SCLK_HALF = `SCLK_HALF_DEF
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // requests
  input wire logic start_i,
  input wire logic pd_req_i,
  output logic busy_o,
  // result words
  output logic [`WORD_BITS-1:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  // link
  sar_link_if.host link
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // a full period must cover both three-stage synchronisers and the launch flop
  // the lengthened first high phase counts up through the top of the phase range
  if (SCLK_HALF < `SCLK_HALF_MIN || SCLK_HALF > 240) begin : g_bad_half
    $error("SCLK_HALF out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  localparam logic [3:0] GAP_CYC = 4'((`ACQ_CYC > `QUIET_CYC) ? `ACQ_CYC : `QUIET_CYC);

  // --------------------------------------------------------------------------
  // data line synchroniser
  // --------------------------------------------------------------------------
  logic [2:0] din_sync_ff;
  logic din_lvl_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      din_sync_ff <= 3'h0;
      din_lvl_ff <= 1'b0;
    end else if (ce_i) begin
      din_sync_ff <= {din_sync_ff[1:0], link.serial_result_out};
      if (din_sync_ff[1] == din_sync_ff[2]) begin
        din_lvl_ff <= din_sync_ff[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // word buffer
  // --------------------------------------------------------------------------
  logic [`WORD_BITS-1:0] buf_mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] buf_cnt_ff;
  logic push;
  logic pop;
  logic [`WORD_BITS-1:0] rx_ff;

  assign pop = word_valid_o && word_ready_i;
  assign word_valid_o = buf_cnt_ff != 2'h0;
  assign word_o = buf_mem_ff[rd_ptr_ff];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      buf_mem_ff[0] <= '0;
      buf_mem_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else if (ce_i) begin
      if (push) begin
        buf_mem_ff[wr_ptr_ff] <= rx_ff;
        wr_ptr_ff <= !wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // --------------------------------------------------------------------------
  // frame sequencer
  // --------------------------------------------------------------------------
  host_state_t state_ff;
  logic [7:0] phase_ff;
  logic [`CNT_W-1:0] falls_ff;
  logic [3:0] gap_ff;
  logic pd_frame_ff;
  logic sclk_ff;
  logic frame_n_ff;
  logic end_frame;

  // a new frame only starts with room in the buffer, so a stalled reader loses nothing
  assign end_frame = state_ff == HS_HIGH && phase_ff == HALF_LAST &&
                     (falls_ff == `LAST_FALL || (pd_frame_ff && falls_ff == `PD_ABORT_FALL));
  assign push = end_frame && !pd_frame_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= HS_IDLE;
      phase_ff <= 8'h00;
      falls_ff <= '0;
      gap_ff <= 4'h0;
      pd_frame_ff <= 1'b0;
      sclk_ff <= 1'b1;
      frame_n_ff <= 1'b1;
      rx_ff <= '0;
    end else if (ce_i) begin
      case (state_ff)
        HS_IDLE: begin
          if (gap_ff != 4'h0) begin
            gap_ff <= gap_ff - 4'h1;
          end else if (start_i && buf_cnt_ff != 2'h2) begin
            frame_n_ff <= 1'b0;
            pd_frame_ff <= pd_req_i;
            falls_ff <= '0;
            // longer first high phase: the leading zero must cross both synchronisers before capture
            phase_ff <= 8'h00 - `FIRST_LEAD;
            state_ff <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (phase_ff != HALF_LAST) begin
            phase_ff <= phase_ff + 8'h01;
          end else if (end_frame) begin
            // abort after fall 4 lands inside the power-down window
            frame_n_ff <= 1'b1;
            gap_ff <= GAP_CYC;
            state_ff <= HS_IDLE;
          end else begin
            // capture just before driving the fall that follows the launch
            rx_ff <= {rx_ff[`WORD_BITS-2:0], din_lvl_ff};
            sclk_ff <= 1'b0;
            falls_ff <= falls_ff + `CNT_W'(1);
            phase_ff <= 8'h00;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (phase_ff != HALF_LAST) begin
            phase_ff <= phase_ff + 8'h01;
          end else begin
            sclk_ff <= 1'b1;
            phase_ff <= 8'h00;
            state_ff <= HS_HIGH;
          end
        end
        default: begin
          state_ff <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.frame_sel_n = frame_n_ff;
  assign busy_o = state_ff != HS_IDLE || gap_ff != 4'h0;

endmodule

// *** dv/sar_link_assertions.sv ***
// checker for the link: frame framing, serial clock and data line timing
`timescale 1ns/1ps
module sar_link_assertions (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // link
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic serial_result_out_o,
  input wire logic serial_result_oe
);
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  logic sclk_q_ff;
  logic [3:0] since_fall_ff;
  logic [4:0] fall_cnt_ff;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) sclk_q_ff <= 1'b1;
    else sclk_q_ff <= sclk;
  end

  // saturates, so a long idle never wraps into a false recent fall
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) since_fall_ff <= 4'hf;
    else if (sclk_q_ff && !sclk) since_fall_ff <= 4'h0;
    else if (since_fall_ff != 4'hf) since_fall_ff <= since_fall_ff + 4'h1;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) fall_cnt_ff <= 5'h00;
    else if (frame_sel_n) fall_cnt_ff <= 5'h00;
    else if (sclk_q_ff && !sclk) fall_cnt_ff <= fall_cnt_ff + 5'h01;
  end

  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  frame_drive_a: assert property ($fell(frame_sel_n) |-> ##[3:8] serial_result_oe)
    else $error("data line not driven after frame start");
  first_zero_a: assert property ($rose(serial_result_oe) |-> !serial_result_out_o)
    else $error("first bit of word is not zero");
  idle_release_a: assert property (frame_sel_n [*8] |-> !serial_result_oe)
    else $error("data line driven outside a frame");
  bit_timing_a: assert property ($changed(serial_result_out_o) && serial_result_oe && $past(serial_result_oe)
    |-> since_fall_ff < 4'h8)
    else $error("data bit changed away from a serial clock fall");
  drive_hold_a: assert property (fall_cnt_ff >= 5'h01 && fall_cnt_ff <= 5'h0f && since_fall_ff >= 4'h6
    && !frame_sel_n |-> serial_result_oe)
    else $error("data line released before the last bit");
  release_last_a: assert property (fall_cnt_ff == 5'h10 && since_fall_ff == 4'h6 |-> !serial_result_oe)
    else $error("data line still driven after the sixteenth fall");
  sclk_framed_a: assert property ($fell(sclk) |-> !frame_sel_n)
    else $error("serial clock fell outside a frame");
  frame_len_a: assert property ($rose(frame_sel_n) |-> fall_cnt_ff == 5'h10 || fall_cnt_ff == 5'h04)
    else $error("frame ended after an unexpected number of falls");
  frame_gap_a: assert property ($rose(frame_sel_n) |-> frame_sel_n [*3])
    else $error("gap between frames too short");
  quiet_gap_a: assert property ($fell(frame_sel_n) |-> !serial_result_oe && !$past(serial_result_oe))
    else $error("frame started without quiet time");
endmodule

// *** dv/sar_adc_serial_readout_tb.sv ***
// bench: both link ends joined, plus a bench-driven frame source on a second converter end
`timescale 1ns/1ps
`include "sar_link_consts.svh"
module sar_adc_serial_readout_tb;
  import sar_link_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [11:0] sample_a = 12'h000;
  logic [9:0] sample_b = 10'h000;
  logic start_i = 1'b0;
  logic pd_req_i = 1'b0;
  logic word_ready_i = 1'b0;
  logic busy_o, word_valid_o, track_a, pd_a, track_b, pd_b, pd_prev;
  logic pd_start = 1'b0;
  logic [15:0] word_o;
  logic [15:0] got_w;
  logic [15:0] got_r;
  logic take_a, done_a, conv_a;
  int n_take = 0;
  int n_done = 0;
  int n_fr = 0;
  int n_full = 0;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int nfall = 0;
  int nf_t[7] = '{16, 1, 5, 7, 16, 12, 16};
  logic pd_t[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  sar_link_if if_a();
  sar_link_if if_b();

  sar_adc_serial_readout #(.RES_BITS(12)) sar_adc_serial_readout_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .sample_i(sample_a), .track_o(track_a), .power_down_o(pd_a), .converting_o(conv_a),
    .sample_take_o(take_a), .done_o(done_a), .link(if_a));
  sar_host_reader #(.SCLK_HALF(8)) sar_host_reader_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .start_i(start_i), .pd_req_i(pd_req_i), .busy_o(busy_o), .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .link(if_a));
  // second converter end, ten-bit, framed by the bench so it can break the host's rules
  sar_adc_serial_readout #(.RES_BITS(10)) sar_adc_serial_readout_inst_b (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .sample_i(sample_b), .track_o(track_b), .power_down_o(pd_b), .converting_o(),
    .sample_take_o(), .done_o(), .link(if_b));
  sar_link_assertions sar_link_assertions_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sclk(if_a.sclk),
    .frame_sel_n(if_a.frame_sel_n), .serial_result_out_o(if_a.serial_result_out_o),
    .serial_result_oe(if_a.serial_result_oe));

  // ----------------------------------------------------------------------------
  // clock, timeout, verdict, compares
  // ----------------------------------------------------------------------------
  initial forever #50 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i) begin
    if (take_a === 1'b1) n_take++;
    if (done_a === 1'b1) n_done++;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------------
  task automatic host_frame(input logic pd);
    int n = 0;
    @(negedge sys_clk_i);
    sample_a = 12'($urandom);
    pd_req_i = pd;
    start_i = 1'b1;
    while (busy_o !== 1'b1 && n < 400) begin
      @(negedge sys_clk_i);
      n++;
    end
    start_i = 1'b0;
    n_fr++;
    n_full += int'(!pd);
    if (!pd) exp_q.push_back({4'h0, sample_a});
    n = 0;
    while (busy_o !== 1'b0 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask

  task automatic pop(input logic chk);
    int n = 0;
    repeat (1 + $urandom_range(3)) @(negedge sys_clk_i);
    while (word_valid_o !== 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (chk) cmp_word(word_o, exp_q[0]);
    void'(exp_q.pop_front());
    word_ready_i = 1'b1;
    @(negedge sys_clk_i);
    word_ready_i = 1'b0;
  endtask

  // captures each bit at the end of a high phase, just before the fall that replaces it
  // also captures at each of the first fifteen rising edges, as a slow host may
  task automatic bfm_frame(input int nf, output logic [15:0] w, output logic [15:0] wr);
    w = 16'h0000;
    wr = 16'h0000;
    @(negedge sys_clk_i);
    if_b.frame_sel_n = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    for (int k = 0; k < nf; k++) begin
      repeat (4) @(negedge sys_clk_i);
      w = {w[14:0], if_b.serial_result_out};
      if_b.sclk = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      if (k < 15) wr = {wr[14:0], if_b.serial_result_out};
      if_b.sclk = 1'b1;
    end
    repeat (4) @(negedge sys_clk_i);
    if (nf == 16) cmp_bit(if_b.serial_result_oe, 1'b0);
    if_b.frame_sel_n = 1'b1;
    repeat (12) @(negedge sys_clk_i);
    cmp_bit(if_b.serial_result_oe, 1'b0);
  endtask

  // ----------------------------------------------------------------------------
  // track/hold monitor on the joined link
  // ----------------------------------------------------------------------------
  always @(negedge if_a.frame_sel_n) begin
    nfall = 0;
    pd_start = pd_a;
  end

  always @(negedge if_a.sclk) begin
    if (!if_a.frame_sel_n) nfall++;
    if (!if_a.frame_sel_n && nfall == 1 && pd_start) begin
      repeat (6) @(negedge sys_clk_i);
      cmp_bit(track_a, 1'b1);
    end
  end

  always @(posedge if_a.sclk) begin
    if (!if_a.frame_sel_n && !pd_start && (nfall == 12 || nfall == 13)) begin
      repeat (6) @(negedge sys_clk_i);
      cmp_bit(track_a, nfall == 13);
    end
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    if_b.sclk = 1'b1;
    if_b.frame_sel_n = 1'b1;
    void'($urandom(32'h646b_fdb7));
    repeat (8) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    fork
      repeat (4) host_frame(1'b0);
      repeat (4) pop(1'b1);
    join
    // fill the buffer until a start is refused, then drain it
    host_frame(1'b0);
    host_frame(1'b0);
    start_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    cmp_bit(busy_o, 1'b0);
    start_i = 1'b0;
    pop(1'b1);
    pop(1'b1);
    cmp_bit(word_valid_o, 1'b0);
    // power-down frame, wake frame, then a good word
    host_frame(1'b1);
    repeat (10) @(negedge sys_clk_i);
    cmp_bit(pd_a, 1'b1);
    cmp_bit(word_valid_o, 1'b0);
    host_frame(1'b0);
    pop(1'b0);
    cmp_bit(pd_a, 1'b0);
    host_frame(1'b0);
    pop(1'b1);
    // stray serial clocks while the frame is high must not count
    repeat (5) begin
      repeat (4) @(negedge sys_clk_i);
      if_b.sclk = ~if_b.sclk;
    end
    if_b.sclk = 1'b1;
    cmp_bit(if_b.serial_result_oe, 1'b0);
    for (int i = 0; i < 7; i++) begin
      sample_b = 10'($urandom);
      pd_prev = pd_b;
      bfm_frame(nf_t[i], got_w, got_r);
      cmp_bit(pd_b, pd_t[i]);
      cmp_bit(track_b, !pd_t[i]);
      if (nf_t[i] == 16 && !pd_prev) cmp_word(got_w, {4'h0, sample_b, 2'b00});
      if (nf_t[i] == 16 && !pd_prev) cmp_word(got_r, {4'h0, sample_b, 2'b00});
    end
    cmp_word(16'(n_take), 16'(n_fr));
    cmp_word(16'(n_done), 16'(n_full));
    cmp_bit(conv_a, 1'b0);
    give_verdict();
  end
endmodule
